/* File: hdl/emba_cfg.svh */
// Purpose: Constants of the explicit message buffer register window
// Assumes: Word indexes; byte address is four times the index
// Notes:   Buffer positions and steps are in bytes
`ifndef EMBA_CFG_SVH
`define EMBA_CFG_SVH
`define EMBA_IDX_MSG_NUM    14'h3517
`define EMBA_IDX_FORMAT     14'h3518
`define EMBA_IDX_INDEX      14'h3519
`define EMBA_IDX_SERVICE    14'h351A
`define EMBA_IDX_CLASS      14'h351B
`define EMBA_IDX_INSTANCE   14'h351C
`define EMBA_IDX_SBYTE      14'h351D
`define EMBA_IDX_SWORD      14'h351E
`define EMBA_IDX_SLONG      14'h351F
`define EMBA_IDX_IRQ_STAT   14'h3520
`define EMBA_IDX_IRQ_MASK   14'h3521
`define EMBA_POS_HEADER     0
`define EMBA_POS_SERVICE    1
`define EMBA_POS_CLASS      2
`define EMBA_POS_RESP_DATA  2
`define EMBA_STEP_BYTE      1
`define EMBA_STEP_WORD      2
`define EMBA_STEP_LONG      4
`define EMBA_LINK_BIT       8
`define EMBA_NOCONN_VALUE   32'h000000FF
`define EMBA_BUSY_VALUE     32'hFFFFFFFF
`define EMBA_FMT_RESET      2'h0
`define EMBA_INDEX_RESET    0
`define EMBA_IRQ_RESET      2'h0
`define EMBA_STAT_RX        0
`define EMBA_STAT_ERR       1
`define EMBA_RESP_OK        2'h0
`define EMBA_RESP_SLVERR    2'h2
`define EMBA_RESP_DECERR    2'h3
`endif

/* File: hdl/emba_pkg.sv */
// Purpose: Types of the explicit message buffer register window
// Assumes: Nothing
// Notes:   Constants live in emba_cfg.svh
package emba_pkg;
	typedef enum logic [1:0] {
		EMBA_FMT_8_8   = 2'h0,
		EMBA_FMT_8_16  = 2'h1,
		EMBA_FMT_16_16 = 2'h2,
		EMBA_FMT_16_8  = 2'h3
	} emba_fmt_type;
	typedef enum logic {
		EMBA_BUS_IDLE   = 1'b0,
		EMBA_BUS_ANSWER = 1'b1
	} emba_bus_type;
endpackage

/* File: hdl/emba_window.sv */
// Purpose: Avalon-MM register window onto the explicit message byte buffer
// Assumes: Message engine writes responses through the engine port
// Notes:   Multi-byte fields are stored low byte first
// Contract
// - Word write steps index 2, long 4
// - Field writes move index past field
// - Reads never change the index
// - No connection: data access answers error
// - Position 0 header, overwritten on send
// - Byte after header is service code
// - Class is 1 or 2 bytes by format
// - Instance is 1 or 2 bytes by format
// - One attribute byte, then request data
// - Response service at 1, data at 2
// - Class, instance width follows format
// - Byte read is sign-extended to 32
// - Byte write keeps only low 8 bits
// - Service register gives byte-wide service access
// - Format codes 0..3 give field widths
// - Byte write stores, then index plus 1
// - Response arrival sets index to 2
// - Writing 0 to message number sends
`timescale 1ns/1ns
`include "emba_cfg.svh"
module emba_window #(
	parameter int INDEX_WIDTH = 8
) (
	input  wire logic                   clock,           // 20 MHz clock
	input  wire logic                   reset_n,         // Async reset, active low
	input  wire logic [15:0]            avs_address,     // Byte address
	input  wire logic                   avs_read,        // Read request
	input  wire logic                   avs_write,       // Write request
	input  wire logic [31:0]            avs_writedata,   // Write data
	input  wire logic [3:0]             avs_byteenable,  // Byte lanes
	output logic      [31:0]            avs_readdata,    // Read data
	output logic                        avs_waitrequest, // Stall
	output logic      [1:0]             avs_response,    // Answer code
	output logic                        irq,             // Level interrupt
	input  wire logic                   link_up,         // Connection exists
	input  wire logic [7:0]             header_byte,     // Header for sending
	output logic                        tx_start,        // Send pulse
	output logic      [1:0]             msg_format,      // Selected format
	input  wire logic                   eng_wr_en,       // Engine byte write
	input  wire logic [INDEX_WIDTH-1:0] eng_wr_addr,     // Engine write position
	input  wire logic [7:0]             eng_wr_data,     // Engine write byte
	input  wire logic                   rx_done,         // Response complete
	input  wire logic [7:0]             rx_count,        // Response byte count
	input  wire logic [INDEX_WIDTH-1:0] eng_rd_addr,     // Engine read position
	output logic      [7:0]             eng_rd_data      // Engine read byte
);
	typedef logic [INDEX_WIDTH-1:0] emba_idx_type;
	localparam int DEPTH = 1 << INDEX_WIDTH;

	logic [7:0]              msg_buf [DEPTH];
	emba_idx_type            index;
	emba_pkg::emba_fmt_type  fmt;
	emba_pkg::emba_bus_type  state;
	logic                    busy;
	logic [7:0]              resp_len;
	logic [1:0]              stat;
	logic [1:0]              mask;
	logic [1:0]              next_stat;
	logic [31:0]             next_rdata;
	logic [1:0]              next_resp;
	logic [31:0]             wd;
	logic [13:0]             word;
	logic                    acc;
	logic                    wr_ok;
	logic                    is_data;
	emba_idx_type            cls_w;
	emba_idx_type            inst_w;
	emba_idx_type            cls_pos;
	emba_idx_type            inst_pos;
	emba_idx_type            attr_pos;
	logic [31:0]             at_idx;
	logic [31:0]             cls_raw;
	logic [31:0]             inst_raw;

	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		logic [31:0] m;
		m = '0;
		for (int k = 0; k < 4; k++) begin
			m[k*8 +: 8] = {8{be[k]}};
		end
		return m;
	endfunction

	// Field width in bytes: class wide for 16/x, instance wide for x/16
	function automatic emba_idx_type field_bytes(input emba_pkg::emba_fmt_type f,
		input logic is_class);
		logic wide;
		if (is_class) begin
			wide = (f == emba_pkg::EMBA_FMT_16_16) || (f == emba_pkg::EMBA_FMT_16_8);
		end else begin
			wide = (f == emba_pkg::EMBA_FMT_8_16) || (f == emba_pkg::EMBA_FMT_16_16);
		end
		return wide ? emba_idx_type'(2) : emba_idx_type'(1);
	endfunction

	function automatic logic [31:0] sext(input logic [31:0] v, input int nb);
		logic [31:0] r;
		case (nb)
			1:       r = {{24{v[7]}}, v[7:0]};
			2:       r = {{16{v[15]}}, v[15:0]};
			default: r = v;
		endcase
		return r;
	endfunction

	function automatic logic [31:0] zext(input logic [31:0] v, input emba_idx_type nb);
		return (nb == emba_idx_type'(2)) ? {16'h0000, v[15:0]} : {24'h000000, v[7:0]};
	endfunction

	assign wd       = avs_writedata & lane_mask(avs_byteenable);
	assign word     = avs_address[15:2];
	assign acc      = (state == emba_pkg::EMBA_BUS_ANSWER);
	assign wr_ok    = acc && avs_write && (avs_response == `EMBA_RESP_OK);
	assign cls_w    = field_bytes(fmt, 1'b1);
	assign inst_w   = field_bytes(fmt, 1'b0);
	assign cls_pos  = emba_idx_type'(`EMBA_POS_CLASS);
	assign inst_pos = emba_idx_type'(cls_pos + cls_w);
	assign attr_pos = emba_idx_type'(inst_pos + inst_w);
	assign at_idx   = {msg_buf[emba_idx_type'(index + 3)], msg_buf[emba_idx_type'(index + 2)],
		msg_buf[emba_idx_type'(index + 1)], msg_buf[index]};
	assign cls_raw  = {16'h0000, msg_buf[emba_idx_type'(cls_pos + 1)], msg_buf[cls_pos]};
	assign inst_raw = {16'h0000, msg_buf[emba_idx_type'(inst_pos + 1)], msg_buf[inst_pos]};

	always_comb begin
		is_data = (word >= `EMBA_IDX_SERVICE) && (word <= `EMBA_IDX_SLONG);
		next_rdata = '0;
		next_resp = `EMBA_RESP_OK;
		case (word)
			`EMBA_IDX_MSG_NUM: begin
				if (!link_up) begin
					next_rdata = `EMBA_NOCONN_VALUE;
				end else if (busy) begin
					next_rdata = `EMBA_BUSY_VALUE;
				end else begin
					next_rdata = {24'h000000, resp_len};
				end
			end
			`EMBA_IDX_FORMAT: begin
				next_rdata = `EMBA_NOCONN_VALUE;
				if (link_up) begin
					next_rdata = {30'h00000000, fmt};
					next_rdata[`EMBA_LINK_BIT] = 1'b1;
				end
				// A live connection refuses a different format
				if (avs_write && link_up && (wd[1:0] != fmt)) begin
					next_resp = `EMBA_RESP_SLVERR;
				end
			end
			`EMBA_IDX_INDEX:    next_rdata = 32'(index);
			`EMBA_IDX_SERVICE:  next_rdata = {24'h000000, msg_buf[`EMBA_POS_SERVICE]};
			`EMBA_IDX_CLASS:    next_rdata = zext(cls_raw, cls_w);
			`EMBA_IDX_INSTANCE: next_rdata = zext(inst_raw, inst_w);
			`EMBA_IDX_SBYTE:    next_rdata = sext(at_idx, 1);
			`EMBA_IDX_SWORD:    next_rdata = sext(at_idx, 2);
			`EMBA_IDX_SLONG:    next_rdata = at_idx;
			`EMBA_IDX_IRQ_STAT: next_rdata = {30'h00000000, stat};
			`EMBA_IDX_IRQ_MASK: next_rdata = {30'h00000000, mask};
			default:            next_resp = `EMBA_RESP_DECERR;
		endcase
		if (is_data && !link_up) begin
			next_rdata = '0;
			next_resp = `EMBA_RESP_SLVERR;
		end
	end

	// Every request waits one cycle, then answers for exactly one cycle
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state <= emba_pkg::EMBA_BUS_IDLE;
			avs_waitrequest <= 1'b1;
			avs_readdata <= '0;
			avs_response <= `EMBA_RESP_OK;
		end else begin
			case (state)
				emba_pkg::EMBA_BUS_IDLE: begin
					if (avs_read || avs_write) begin
						state <= emba_pkg::EMBA_BUS_ANSWER;
						avs_waitrequest <= 1'b0;
						avs_readdata <= avs_read ? next_rdata : '0;
						avs_response <= next_resp;
					end
				end
				emba_pkg::EMBA_BUS_ANSWER: begin
					state <= emba_pkg::EMBA_BUS_IDLE;
					avs_waitrequest <= 1'b1;
				end
				default: begin
					state <= emba_pkg::EMBA_BUS_IDLE;
					avs_waitrequest <= 1'b1;
				end
			endcase
		end
	end

	// Bus stores win over engine stores to the same byte
	always_ff @(posedge clock) begin
		if (eng_wr_en) begin
			msg_buf[eng_wr_addr] <= eng_wr_data;
		end
		if (wr_ok) begin
			case (word)
				`EMBA_IDX_MSG_NUM: begin
					if (wd == 32'h00000000) begin
						msg_buf[`EMBA_POS_HEADER] <= header_byte;
					end
				end
				`EMBA_IDX_SERVICE: msg_buf[`EMBA_POS_SERVICE] <= wd[7:0];
				`EMBA_IDX_CLASS: begin
					msg_buf[cls_pos] <= wd[7:0];
					if (cls_w == emba_idx_type'(2)) begin
						msg_buf[emba_idx_type'(cls_pos + 1)] <= wd[15:8];
					end
				end
				`EMBA_IDX_INSTANCE: begin
					msg_buf[inst_pos] <= wd[7:0];
					if (inst_w == emba_idx_type'(2)) begin
						msg_buf[emba_idx_type'(inst_pos + 1)] <= wd[15:8];
					end
				end
				`EMBA_IDX_SBYTE: msg_buf[index] <= wd[7:0];
				`EMBA_IDX_SWORD: begin
					msg_buf[index] <= wd[7:0];
					msg_buf[emba_idx_type'(index + 1)] <= wd[15:8];
				end
				`EMBA_IDX_SLONG: begin
					for (int k = 0; k < 4; k++) begin
						msg_buf[emba_idx_type'(index + k)] <= wd[k*8 +: 8];
					end
				end
				default: ;
			endcase
		end
		eng_rd_data <= msg_buf[eng_rd_addr];
	end

	// Response arrival outranks a bus write in the same cycle
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			index <= emba_idx_type'(`EMBA_INDEX_RESET);
		end else if (rx_done) begin
			index <= emba_idx_type'(`EMBA_POS_RESP_DATA);
		end else if (wr_ok) begin
			case (word)
				`EMBA_IDX_INDEX:    index <= wd[INDEX_WIDTH-1:0];
				`EMBA_IDX_SERVICE:  index <= cls_pos;
				`EMBA_IDX_CLASS:    index <= inst_pos;
				`EMBA_IDX_INSTANCE: index <= attr_pos;
				`EMBA_IDX_SBYTE:    index <= emba_idx_type'(index + `EMBA_STEP_BYTE);
				`EMBA_IDX_SWORD:    index <= emba_idx_type'(index + `EMBA_STEP_WORD);
				`EMBA_IDX_SLONG:    index <= emba_idx_type'(index + `EMBA_STEP_LONG);
				default:            index <= index;
			endcase
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			fmt <= emba_pkg::emba_fmt_type'(`EMBA_FMT_RESET);
			msg_format <= `EMBA_FMT_RESET;
		end else begin
			if (wr_ok && (word == `EMBA_IDX_FORMAT)) begin
				fmt <= emba_pkg::emba_fmt_type'(wd[1:0]);
			end
			msg_format <= fmt;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tx_start <= 1'b0;
			busy <= 1'b0;
			resp_len <= 8'h00;
		end else begin
			tx_start <= wr_ok && (word == `EMBA_IDX_MSG_NUM) && (wd == 32'h00000000);
			if (rx_done) begin
				busy <= 1'b0;
				resp_len <= rx_count;
			end else if (wr_ok && (word == `EMBA_IDX_MSG_NUM)) begin
				busy <= (wd == 32'h00000000);
				resp_len <= 8'h00;
			end
		end
	end

	// Event set wins over the clear by a status read
	always_comb begin
		next_stat = stat;
		if (acc && avs_read && (word == `EMBA_IDX_IRQ_STAT)) begin
			next_stat = 2'h0;
		end
		next_stat[`EMBA_STAT_RX] = next_stat[`EMBA_STAT_RX] | rx_done;
		next_stat[`EMBA_STAT_ERR] = next_stat[`EMBA_STAT_ERR]
			| (acc && (avs_response != `EMBA_RESP_OK));
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			stat <= `EMBA_IRQ_RESET;
			mask <= `EMBA_IRQ_RESET;
			irq <= 1'b0;
		end else begin
			stat <= next_stat;
			if (wr_ok && (word == `EMBA_IDX_IRQ_MASK)) begin
				mask <= wd[1:0];
			end
			irq <= |(next_stat & mask);
		end
	end

	default clocking emba_cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	sequence s_new_req;
		(state == emba_pkg::EMBA_BUS_IDLE) && (avs_read || avs_write);
	endsequence
	sequence s_wr(logic [13:0] w);
		wr_ok && (word == w) && !rx_done;
	endsequence
	sequence s_rd_data;
		acc && avs_read && is_data && !rx_done;
	endsequence

	// Engine store with no bus store in the same cycle
	sequence s_eng_only;
		eng_wr_en && !wr_ok;
	endsequence

	chk_answer_one_cycle: assert property (s_new_req |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("answer not one cycle after request");
	chk_word_long_step: assert property (s_wr(`EMBA_IDX_SWORD) or s_wr(`EMBA_IDX_SLONG)
		|=> index == emba_idx_type'($past(index) + ($past(word) == `EMBA_IDX_SWORD ? 2 : 4)))
		else $error("index step wrong after word or long write");
	chk_field_index: assert property (s_wr(`EMBA_IDX_INSTANCE)
		|=> index == emba_idx_type'(2 + $past(cls_w) + $past(inst_w)))
		else $error("index not at attribute after instance write");
	chk_read_keeps_index: assert property (s_rd_data |=> $stable(index))
		else $error("data read moved the index");
	chk_noconn_error: assert property (s_new_req and (is_data && !link_up)
		|=> avs_response == `EMBA_RESP_SLVERR)
		else $error("no error answer without connection");
	chk_header_send: assert property (s_wr(`EMBA_IDX_MSG_NUM)
		and (wd == 32'h00000000) |=> tx_start && msg_buf[`EMBA_POS_HEADER] == $past(header_byte))
		else $error("send did not start with header");
	chk_byte_store: assert property (s_wr(`EMBA_IDX_SBYTE)
		|=> index == emba_idx_type'($past(index) + 1)
		&& msg_buf[$past(index)] == $past(wd[7:0]))
		else $error("byte write wrong");
	chk_resp_index: assert property (rx_done |=> index == emba_idx_type'(2))
		else $error("index not 2 after response");
	chk_byte_sext: assert property (s_new_req
		and (avs_read && word == `EMBA_IDX_SBYTE && link_up)
		|=> avs_readdata[31:8] == {24{avs_readdata[7]}})
		else $error("byte read not sign-extended");
	chk_service_store: assert property (s_wr(`EMBA_IDX_SERVICE)
		|=> msg_buf[`EMBA_POS_SERVICE] == $past(wd[7:0]) && index == emba_idx_type'(2))
		else $error("service write wrong");
	chk_class_store: assert property (s_wr(`EMBA_IDX_CLASS)
		|=> msg_buf[`EMBA_POS_CLASS] == $past(wd[7:0]))
		else $error("class low byte not stored");
	chk_inst_store: assert property (s_wr(`EMBA_IDX_INSTANCE)
		|=> msg_buf[$past(inst_pos)] == $past(wd[7:0]))
		else $error("instance low byte not stored");
	chk_engine_store: assert property (s_eng_only
		|=> msg_buf[$past(eng_wr_addr)] == $past(eng_wr_data))
		else $error("engine byte not stored");
	chk_refused_keeps: assert property (acc && (avs_response != `EMBA_RESP_OK) && !rx_done
		|=> $stable(index))
		else $error("refused access moved the index");
	chk_send_pulse: assert property (tx_start |=> !tx_start)
		else $error("send pulse longer than one cycle");
	chk_rx_set_wins: assert property (rx_done |=> stat[`EMBA_STAT_RX])
		else $error("response flag lost");
	chk_fmt_refused: assert property (s_new_req
		and (avs_write && word == `EMBA_IDX_FORMAT && link_up && (wd[1:0] != fmt))
		|=> avs_response == `EMBA_RESP_SLVERR ##1 $stable(fmt))
		else $error("format change not refused");
endmodule

/* File: tb/emba_engine.sv */
// Purpose: Message engine model on the far side of the buffer window
// Assumes: One response per send, written DELAY cycles after it reads the header and service bytes
// Notes:   Reports the header and service bytes it read at send time
`timescale 1ns/1ns
module emba_engine #(
	parameter int DELAY = 20
) (
	input  wire logic       clock,        // Block clock
	input  wire logic       reset_n,      // Async reset, active low
	input  wire logic       tx_start,     // Send pulse
	input  wire logic [7:0] eng_rd_data,  // Buffer byte read
	output logic      [7:0] eng_rd_addr,  // Buffer read position
	output logic            eng_wr_en,    // Byte write strobe
	output logic      [7:0] eng_wr_addr,  // Byte write position
	output logic      [7:0] eng_wr_data,  // Byte write value
	output logic            rx_done,      // Response complete
	output logic      [7:0] rx_count,     // Response length
	output logic      [7:0] seen_header,  // Header byte at send
	output logic      [7:0] seen_service  // Service byte at send
);
	initial begin
		{eng_rd_addr, eng_wr_en, eng_wr_addr, eng_wr_data, rx_done, rx_count} = '0;
		{seen_header, seen_service} = '0;
	end
	always begin
		@(posedge clock);
		if (reset_n === 1'b1 && tx_start === 1'b1) begin
			eng_rd_addr <= 8'h00;
			repeat (2) @(posedge clock);
			seen_header <= eng_rd_data;
			eng_rd_addr <= 8'h01;
			repeat (2) @(posedge clock);
			seen_service <= eng_rd_data;
			repeat (DELAY) @(posedge clock);
			eng_wr_en <= 1'b1;
			eng_wr_addr <= 8'h01;
			eng_wr_data <= eng_rd_data | 8'h80;
			@(posedge clock);
			eng_wr_addr <= 8'h02;
			eng_wr_data <= 8'hA5;
			@(posedge clock);
			eng_wr_en <= 1'b0;
			eng_wr_data <= 8'h5A;
			rx_done <= 1'b1;
			rx_count <= 8'h03;
			@(posedge clock);
			rx_done <= 1'b0;
			rx_count <= 8'hFC;
		end
	end
endmodule

/* File: tb/explicit_message_buffer_access_bench.sv */
// Purpose: Self-checking bench of the message buffer register window
// Assumes: One wait cycle per access, engine model answers sends
// Notes:   Driver queues expectations, monitor pops them per answer
`timescale 1ns/1ns
`include "emba_cfg.svh"
module explicit_message_buffer_access_bench;
	logic        clock = 0, reset_n = 0, avs_read = 0, avs_write = 0, link_up = 0;
	logic        avs_waitrequest, irq, tx_start, eng_wr_en, rx_done;
	logic [15:0] avs_address = 0;
	logic [31:0] avs_writedata = 0, avs_readdata, d;
	logic [1:0]  avs_response, msg_format;
	logic [7:0]  eng_wr_addr, eng_wr_data, rx_count, eng_rd_addr, eng_rd_data, hdr, svc;
	logic [33:0] exp_q[$];
	logic [33:0] e;
	int          errors = 0, tests_run = 0, seed = 23955, f, cw, iw, k, n;
	always #25 clock = ~clock;
	emba_window dut (.clock(clock), .reset_n(reset_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.avs_response(avs_response), .irq(irq), .link_up(link_up), .header_byte(8'h5C),
		.tx_start(tx_start), .msg_format(msg_format), .eng_wr_en(eng_wr_en),
		.eng_wr_addr(eng_wr_addr), .eng_wr_data(eng_wr_data), .rx_done(rx_done),
		.rx_count(rx_count), .eng_rd_addr(eng_rd_addr), .eng_rd_data(eng_rd_data));
	emba_engine eng (.clock(clock), .reset_n(reset_n), .tx_start(tx_start),
		.eng_rd_data(eng_rd_data), .eng_rd_addr(eng_rd_addr), .eng_wr_en(eng_wr_en),
		.eng_wr_addr(eng_wr_addr), .eng_wr_data(eng_wr_data), .rx_done(rx_done),
		.rx_count(rx_count), .seen_header(hdr), .seen_service(svc));
	task summarize;
		if (errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] want);
		tests_run++;
		if (seen !== want) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
		end
	endtask
	task acc(input logic w, input logic [13:0] i, input logic [31:0] wd, input logic [31:0] x,
		input logic [1:0] r);
		int c;
		@(posedge clock);
		exp_q.push_back({x, r});
		avs_address <= {i, 2'b00};
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= wd;
		c = 0;
		do begin
			@(posedge clock);
			c++;
		end while (avs_waitrequest !== 1'b0 && c < 50);
		if (c >= 50) begin
			errors++;
			summarize();
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task rd(input logic [13:0] i, input logic [31:0] x);
		acc(1'b0, i, 32'h0, x, `EMBA_RESP_OK);
	endtask
	task wr(input logic [13:0] i, input logic [31:0] wd);
		acc(1'b1, i, wd, 32'h0, `EMBA_RESP_OK);
	endtask
	task irq_is(input logic v);
		repeat (2) @(posedge clock);
		chk({31'h0, irq}, {31'h0, v});
	endtask
	always @(posedge clock) begin
		if (reset_n === 1'b1 && (avs_read | avs_write) === 1'b1 && avs_waitrequest === 1'b0) begin
			e = exp_q.pop_front();
			chk(avs_readdata, e[33:2]);
			chk({30'h0, avs_response}, {30'h0, e[1:0]});
		end
	end
	initial begin
		repeat (10) @(posedge clock);
		reset_n <= 1'b1;
		rd(`EMBA_IDX_INDEX, 32'h0);
		for (f = 0; f < 4; f++) begin
			link_up <= 1'b0;
			wr(`EMBA_IDX_FORMAT, 32'(f));
			link_up <= 1'b1;
			cw = f[1] ? 2 : 1;
			iw = (f == 1 || f == 2) ? 2 : 1;
			rd(`EMBA_IDX_FORMAT, 32'h100 | 32'(f));
			chk({30'h0, msg_format}, 32'(f));
			wr(`EMBA_IDX_SERVICE, 32'hFFFFFF0E);
			rd(`EMBA_IDX_INDEX, 32'h2);
			wr(`EMBA_IDX_CLASS, 32'h1234);
			rd(`EMBA_IDX_INDEX, 32'(2 + cw));
			wr(`EMBA_IDX_INSTANCE, 32'h5678);
			rd(`EMBA_IDX_INDEX, 32'(2 + cw + iw));
			rd(`EMBA_IDX_CLASS, cw == 2 ? 32'h1234 : 32'h34);
			rd(`EMBA_IDX_INSTANCE, iw == 2 ? 32'h5678 : 32'h78);
			rd(`EMBA_IDX_SERVICE, 32'h0E);
			rd(`EMBA_IDX_INDEX, 32'(2 + cw + iw));
			wr(`EMBA_IDX_SBYTE, 32'h07);
			rd(`EMBA_IDX_INDEX, 32'(3 + cw + iw));
			acc(1'b1, `EMBA_IDX_FORMAT, 32'(f ^ 1), 32'h0, `EMBA_RESP_SLVERR);
		end
		for (k = 0; k < 8; k++) begin
			d = $random(seed);
			d[7] = k[0];
			wr(`EMBA_IDX_INDEX, 32'h40);
			wr(`EMBA_IDX_SBYTE, d);
			rd(`EMBA_IDX_INDEX, 32'h41);
			wr(`EMBA_IDX_INDEX, 32'h40);
			rd(`EMBA_IDX_SBYTE, {{24{d[7]}}, d[7:0]});
		end
		wr(`EMBA_IDX_INDEX, 32'h2);
		wr(`EMBA_IDX_SWORD, 32'hBEEF);
		wr(`EMBA_IDX_SBYTE, 32'h9C);
		rd(`EMBA_IDX_CLASS, 32'hBEEF);
		rd(`EMBA_IDX_INSTANCE, 32'h9C);
		wr(`EMBA_IDX_INDEX, 32'h10);
		wr(`EMBA_IDX_SWORD, 32'h8001);
		rd(`EMBA_IDX_INDEX, 32'h12);
		wr(`EMBA_IDX_SLONG, 32'h12345678);
		rd(`EMBA_IDX_INDEX, 32'h16);
		wr(`EMBA_IDX_INDEX, 32'h10);
		rd(`EMBA_IDX_SWORD, 32'hFFFF8001);
		wr(`EMBA_IDX_INDEX, 32'h12);
		rd(`EMBA_IDX_SLONG, 32'h12345678);
		wr(`EMBA_IDX_IRQ_MASK, 32'h0);
		link_up <= 1'b0;
		acc(1'b0, `EMBA_IDX_SBYTE, 32'h0, 32'h0, `EMBA_RESP_SLVERR);
		acc(1'b1, `EMBA_IDX_SBYTE, 32'h5, 32'h0, `EMBA_RESP_SLVERR);
		acc(1'b0, 14'h0100, 32'h0, 32'h0, `EMBA_RESP_DECERR);
		link_up <= 1'b1;
		rd(`EMBA_IDX_INDEX, 32'h12);
		irq_is(1'b0);
		wr(`EMBA_IDX_IRQ_MASK, 32'h2);
		irq_is(1'b1);
		rd(`EMBA_IDX_IRQ_STAT, 32'h2);
		irq_is(1'b0);
		wr(`EMBA_IDX_IRQ_MASK, 32'h1);
		link_up <= 1'b0;
		wr(`EMBA_IDX_FORMAT, 32'h0);
		link_up <= 1'b1;
		wr(`EMBA_IDX_INDEX, 32'h0);
		wr(`EMBA_IDX_SBYTE, 32'h77);
		wr(`EMBA_IDX_SERVICE, 32'h0E);
		wr(`EMBA_IDX_MSG_NUM, 32'h0);
		rd(`EMBA_IDX_MSG_NUM, 32'hFFFFFFFF);
		n = 0;
		while (irq !== 1'b1 && n < 200) begin
			@(posedge clock);
			n++;
		end
		if (n >= 200) begin
			errors++;
			summarize();
		end
		chk({24'h0, hdr}, 32'h5C);
		chk({24'h0, svc}, 32'h0E);
		rd(`EMBA_IDX_INDEX, 32'h2);
		rd(`EMBA_IDX_SBYTE, 32'hFFFFFFA5);
		wr(`EMBA_IDX_INDEX, 32'h1);
		rd(`EMBA_IDX_SERVICE, 32'h8E);
		rd(`EMBA_IDX_MSG_NUM, 32'h3);
		rd(`EMBA_IDX_IRQ_STAT, 32'h1);
		irq_is(1'b0);
		summarize();
	end
endmodule
